/* File: rtl/rfs_top.sv */
// Purpose: FIR back end: coefficient window, output scaling, unique B, decimation sync.
// Assumes: Single 20 MHz clock; samples arrive from the comb decimator as strobes.
// Notes: Scaler maps 23-bit results to words; sync pins are split into in/out/oe.
`timescale 1ns/10ps

module rfs_top import rfs_pkg::*; #(
	parameter int DEPTH = RFS_COEF_DEPTH
) (
	input wire logic clk, // clock, 20 MHz
	input wire logic rst_b, // sync reset, active low
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write
	input wire logic [13:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	output logic wb_err_o, // Wishbone error, unmapped address
	input wire logic sampleValid, // new sample from comb decimator
	input wire logic [17:0] sampleA, // A channel (or I) sample
	input wire logic [17:0] sampleB, // B channel (or Q) sample
	input wire logic combSyncPinIn, // comb sync pad level
	output logic combSyncPinOut, // comb sync drive
	output logic combSyncPinOe_b, // comb sync enable, low drives
	input wire logic firSyncPinIn, // FIR sync pad level
	output logic firSyncPinOut, // FIR sync drive
	output logic firSyncPinOe_b, // FIR sync enable, low drives
	output logic combTwoStrobe, // comb stage two output phase
	output logic combFiveStrobe, // comb stage five output phase
	output logic outValid, // output word strobe
	output logic [31:0] outputPortWord, // output word
	output logic softReset // soft reset held from mode register
);
	localparam int AW = $clog2(DEPTH);

	logic [7:0] mode_q;
	logic [3:0] outCtl_q;
	logic [7:0] coefBaseOffset_q;
	logic [7:0] nTapsM1_q;
	logic [23:0] decim_q;
	logic [1:0] outWidth_q;
	logic ack_q, err_q;
	logic [31:0] rdat_q;
	logic [AW-1:0] coefRdAddr;
	logic [RFS_COEF_W-1:0] coefData;
	logic isMaster, uniqueB, diversity;
	logic [7:0] c2Cnt_q, c5Cnt_q, firCnt_q;
	logic combSyncSeen, firSyncSeen;
	logic c2Wrap, c5Wrap, firWrap, combPulse;
	rfs_seq_e state_q;
	logic [AW-1:0] idx_q;
	logic [7:0] tap_q;
	logic signed [RFS_RES_W+20:0] accA_q, accB_q;
	logic macValid_q, doneValid_q, busyB_q;
	logic macLast_q, phaseB_q, emitB_q, selB_q;
	logic [7:0] c2Base, c5Base, firBase;
	logic signed [RFS_RES_W-1:0] result;

	function automatic logic [11:0] regIndex(input logic [13:0] byteAdr);
		regIndex = byteAdr[13:2];
	endfunction

	// One step of a decimation counter that wraps to zero once it reaches the programmed value.
	function automatic logic [7:0] cntStep(input logic [7:0] cnt, input logic [7:0] lim);
		cntStep = (cnt == lim) ? 8'h00 : cnt + 8'h01;
	endfunction

	function automatic logic [23:0] laneMerge(input logic [23:0] old, input logic [31:0] d, input logic [3:0] sel);
		logic [23:0] r;
		r = old;
		for (int i = 0; i < 3; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		laneMerge = r;
	endfunction

	wire busReq = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
	wire [11:0] idx = regIndex(wb_adr_i);
	wire coefHit = idx < 12'(DEPTH);
	wire regHit = idx == RFS_IDX_MODE || idx == RFS_IDX_OUTCTL || idx == RFS_IDX_CBASE ||
		idx == RFS_IDX_NTAPS || idx == RFS_IDX_DECIM || idx == RFS_IDX_STATUS || idx == RFS_IDX_OWIDTH;
	wire wrStb = busReq && wb_we_i;

	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign wb_dat_o = rdat_q;
	assign softReset = mode_q[RFS_MODE_SOFTRST];
	assign isMaster = mode_q[RFS_MODE_MASTER];
	assign diversity = mode_q[RFS_MODE_DIVERSITY];
	assign uniqueB = outCtl_q[RFS_OUT_UNIQUEB] && diversity;

	// Single-cycle answer: ack or err one edge after the request is seen.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			ack_q <= busReq && (coefHit || regHit);
			err_q <= busReq && !(coefHit || regHit);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdat_q <= 32'h00000000;
		end else if (busReq) begin
			case (idx)
				RFS_IDX_MODE: rdat_q <= {24'h000000, mode_q};
				RFS_IDX_OUTCTL: rdat_q <= {28'h0000000, outCtl_q};
				RFS_IDX_CBASE: rdat_q <= {24'h000000, coefBaseOffset_q};
				RFS_IDX_NTAPS: rdat_q <= {24'h000000, nTapsM1_q};
				RFS_IDX_DECIM: rdat_q <= {8'h00, decim_q};
				RFS_IDX_OWIDTH: rdat_q <= {30'h00000000, outWidth_q};
				RFS_IDX_STATUS: rdat_q <= {26'h0000000, uniqueB, isMaster, busyB_q,
					state_q != RFS_IDLE, firSyncSeen, combSyncSeen};
				default: rdat_q <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mode_q <= RFS_MODE_RST;
			outCtl_q <= RFS_OUTCTL_RST;
			coefBaseOffset_q <= RFS_CBASE_RST;
			nTapsM1_q <= RFS_NTAPS_RST;
			decim_q <= RFS_DECIM_RST;
			outWidth_q <= RFS_OW_16;
		end else if (wrStb && wb_sel_i[0]) begin
			case (idx)
				RFS_IDX_MODE: mode_q <= {4'h0, wb_dat_i[3:0]};
				RFS_IDX_OUTCTL: outCtl_q <= wb_dat_i[3:0];
				RFS_IDX_CBASE: coefBaseOffset_q <= wb_dat_i[7:0];
				RFS_IDX_NTAPS: nTapsM1_q <= wb_dat_i[7:0];
				RFS_IDX_DECIM: decim_q <= laneMerge(decim_q, wb_dat_i, wb_sel_i);
				RFS_IDX_OWIDTH: outWidth_q <= wb_dat_i[1:0];
				default: mode_q <= mode_q;
			endcase
		end
	end

	rfs_coef_ram #(.DEPTH(DEPTH), .WIDTH(RFS_COEF_W)) uCoef (
		.clk(clk),
		.wrEn(wrStb && coefHit && wb_sel_i[0]),
		.wrAddr(AW'(idx)),
		.wrData(wb_dat_i[RFS_COEF_W-1:0]),
		.rdAddr(coefRdAddr),
		.rdData(coefData)
	);

	// Sync pins: the pad value is what both roles act on, so a master sees its own pulse.
	// own pulse readback
	assign combSyncSeen = combSyncPinIn;
	assign firSyncSeen = firSyncPinIn;

	// A pad pulse stands in the cycle just after the master's wrap, so the counters restart from that phase.
	// The master's own pulse then finds them already there, and its period is left untouched.
	always_comb begin
		c2Base = c2Cnt_q;
		c5Base = c5Cnt_q;
		firBase = firCnt_q;
		if (combSyncSeen || firSyncSeen) begin
			c2Base = 8'h00;
			c5Base = 8'h00;
		end
		if (firSyncSeen) begin
			firBase = 8'h00;
		end
	end

	assign c2Wrap = c2Base == decim_q[7:0];
	assign c5Wrap = c5Base == decim_q[15:8];
	assign combPulse = c2Wrap && c5Wrap;
	assign firWrap = firBase == decim_q[23:16];

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			combSyncPinOut <= 1'b0;
			firSyncPinOut <= 1'b0;
		end else begin
			combSyncPinOut <= isMaster && combPulse && !softReset;
			firSyncPinOut <= isMaster && combPulse && firWrap && !softReset;
		end
	end

	assign combSyncPinOe_b = !isMaster;
	assign firSyncPinOe_b = !isMaster;

	always_ff @(posedge clk) begin
		if (!rst_b || softReset) begin
			c2Cnt_q <= 8'h00;
			c5Cnt_q <= 8'h00;
			firCnt_q <= 8'h00;
		end else begin
			c2Cnt_q <= cntStep(c2Base, decim_q[7:0]);
			if (c2Wrap) begin
				c5Cnt_q <= cntStep(c5Base, decim_q[15:8]);
			end else begin
				c5Cnt_q <= c5Base;
			end
			if (combPulse) begin
				firCnt_q <= cntStep(firBase, decim_q[23:16]);
			end else begin
				firCnt_q <= firBase;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			combTwoStrobe <= 1'b0;
			combFiveStrobe <= 1'b0;
		end else begin
			combTwoStrobe <= c2Wrap && !softReset;
			combFiveStrobe <= combPulse && !softReset;
		end
	end

	// Sequencer: A products then B products per tap; the sample window is held outside.
	// index starts at base
	assign coefRdAddr = idx_q;

	always_ff @(posedge clk) begin
		if (!rst_b || softReset) begin
			state_q <= RFS_IDLE;
			idx_q <= '0;
			tap_q <= 8'h00;
			busyB_q <= 1'b0;
		end else begin
			case (state_q)
				RFS_IDLE: begin
					if (sampleValid) begin
						state_q <= RFS_RUN_A;
						idx_q <= AW'(coefBaseOffset_q);
						tap_q <= 8'h00;
					end
				end
				RFS_RUN_A: begin
					if (diversity) begin
						state_q <= RFS_RUN_B;
						busyB_q <= 1'b1;
						if (uniqueB) begin
							idx_q <= idx_q + AW'(1);
						end
					end else begin
						idx_q <= idx_q + AW'(1);
						tap_q <= tap_q + 8'h01;
						if (tap_q == nTapsM1_q) begin
							state_q <= RFS_IDLE;
						end
					end
				end
				RFS_RUN_B: begin
					busyB_q <= 1'b0;
					idx_q <= idx_q + AW'(1);
					tap_q <= tap_q + 8'h01;
					state_q <= (tap_q == nTapsM1_q) ? RFS_IDLE : RFS_RUN_A;
				end
				default: state_q <= RFS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b || softReset) begin
			accA_q <= '0;
			accB_q <= '0;
			macValid_q <= 1'b0;
			doneValid_q <= 1'b0;
			phaseB_q <= 1'b0;
			macLast_q <= 1'b0;
			emitB_q <= 1'b0;
			selB_q <= 1'b0;
		end else begin
			macValid_q <= state_q != RFS_IDLE;
			phaseB_q <= state_q == RFS_RUN_B;
			macLast_q <= state_q != RFS_IDLE && (tap_q == nTapsM1_q) && (state_q == RFS_RUN_B || !diversity);
			// The last product is added one edge after macLast_q, so the words are handed over after that.
			// In diversity mode the B word follows the A word in the next cycle.
			doneValid_q <= macLast_q || emitB_q;
			emitB_q <= macLast_q && diversity;
			selB_q <= emitB_q;
			if (state_q == RFS_IDLE && sampleValid) begin
				accA_q <= '0;
				accB_q <= '0;
			end else if (macValid_q && phaseB_q) begin
				accB_q <= accB_q + 44'(signed'(coefData) * signed'(sampleB));
			end else if (macValid_q) begin
				accA_q <= accA_q + 44'(signed'(coefData) * signed'(sampleA));
			end
		end
	end

	// Products carry 17 fraction bits of the sample; the 23-bit result keeps the headroom.
	// Each channel owns its product cycle, so a shared tap is never counted twice.
	assign result = selB_q ? accB_q[RFS_RES_W+16:17] : accA_q[RFS_RES_W+16:17];

	rfs_out_scaler uScale (
		.clk(clk),
		.rst_b(rst_b),
		.inValid(doneValid_q),
		.firResult23b(result),
		.scale(outCtl_q[2:0]),
		.wideWord(outWidth_q != RFS_OW_16),
		.outValid(outValid),
		.outputPortWord(outputPortWord)
	);
endmodule

/* File: rtl/rfs_pkg.sv */
// Purpose: Shared constants for the FIR scaling and decimation sync back end.
// Assumes: Wishbone byte address is four times the printed register index.
// Notes: Register indices are kept as printed; bus addresses derive from them.
package rfs_pkg;
	localparam logic [11:0] RFS_IDX_MODE = 12'h300;
	localparam logic [11:0] RFS_IDX_OUTCTL = 12'h309;
	localparam logic [11:0] RFS_IDX_CBASE = 12'h30b;
	localparam logic [11:0] RFS_IDX_DECIM = 12'h310;
	localparam logic [11:0] RFS_IDX_NTAPS = 12'h30c;
	localparam logic [11:0] RFS_IDX_STATUS = 12'h311;
	localparam logic [11:0] RFS_IDX_OWIDTH = 12'h312;
	localparam logic [11:0] RFS_IDX_COEF0 = 12'h000;
	localparam int RFS_MODE_SOFTRST = 0;
	localparam int RFS_MODE_DIVERSITY = 1;
	localparam int RFS_MODE_MASTER = 3;
	localparam int RFS_OUT_UNIQUEB = 3;
	localparam logic [7:0] RFS_MODE_RST = 8'h01;
	localparam logic [3:0] RFS_OUTCTL_RST = 4'h4;
	localparam logic [7:0] RFS_CBASE_RST = 8'h00;
	localparam logic [7:0] RFS_NTAPS_RST = 8'h00;
	localparam logic [23:0] RFS_DECIM_RST = 24'h000000;
	localparam logic [2:0] RFS_SCALE_UNITY = 3'h4;
	localparam int RFS_COEF_DEPTH = 256;
	localparam int RFS_COEF_W = 20;
	localparam int RFS_RES_W = 23;
	localparam int RFS_OUT_W = 16;
	localparam logic [1:0] RFS_OW_16 = 2'h0;
	typedef enum logic [1:0] {RFS_IDLE, RFS_RUN_A, RFS_RUN_B} rfs_seq_e;
endpackage

/* File: rtl/rfs_coef_ram.sv */
// Purpose: Coefficient memory with registered read data.
// Assumes: One write port, one read port, same clock.
// Notes: Contents are not cleared by reset.
`timescale 1ns/10ps
module rfs_coef_ram import rfs_pkg::*; #(
	parameter int DEPTH = RFS_COEF_DEPTH,
	parameter int WIDTH = RFS_COEF_W
) (
	input wire logic clk, // clock
	input wire logic wrEn, // write strobe
	input wire logic [$clog2(DEPTH)-1:0] wrAddr, // write address
	input wire logic [WIDTH-1:0] wrData, // write data
	input wire logic [$clog2(DEPTH)-1:0] rdAddr, // read address
	output logic [WIDTH-1:0] rdData // registered read data
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clk) begin
		rdData <= mem[rdAddr];
	end
endmodule

/* File: rtl/rfs_out_scaler.sv */
// Purpose: Scales the 23-bit filter result into the output word.
// Assumes: Result is two's complement; scale field 0..7.
// Notes: Wide serial words bypass scaling and carry the result sign-extended.
`timescale 1ns/10ps
module rfs_out_scaler import rfs_pkg::*; (
	input wire logic clk, // clock
	input wire logic rst_b, // sync reset, active low
	input wire logic inValid, // result strobe
	input wire logic [RFS_RES_W-1:0] firResult23b, // filter result
	input wire logic [2:0] scale, // output scale field
	input wire logic wideWord, // serial 24/32-bit word selected
	output logic outValid, // word strobe
	output logic [31:0] outputPortWord // scaled word, 16 bits low when narrow
);
	// Result in a 40-bit frame shifted by seven minus scale; scale 0 is sixteen times scale 4.
	logic signed [39:0] framed;
	logic signed [39:0] rounded;
	logic [31:0] word;

	always_comb begin
		framed = 40'(signed'(firResult23b)) <<< (3'h7 - scale);
		// At scale 4 the top 16 of the 23 result bits are kept: drop ten frame bits, rounding half up.
		rounded = (framed + 40'sh0000000200) >>> 10;
		if (rounded > 40'sh7fff) begin
			word = 32'h00007fff;
		end else if (rounded < -40'sh8000) begin
			word = 32'h00008000;
		end else begin
			word = {16'h0000, rounded[15:0]};
		end
		// Wide serial words ignore the scale field entirely.
		if (wideWord) begin
			word = 32'(signed'(firResult23b));
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			outValid <= 1'b0;
			outputPortWord <= 32'h00000000;
		end else begin
			outValid <= inValid;
			if (inValid) begin
				outputPortWord <= word;
			end
		end
	end
endmodule

/* File: test/rfs_top_properties.sv */
// Purpose: Bus handshake and sync pin checks for the FIR back end.
// Assumes: One clock; rst_b is synchronous and active low.
// Notes: Bound to every instance of rfs_top.
`timescale 1ns/10ps
module rfs_top_properties (
	input wire logic clk, // clock
	input wire logic rst_b, // reset, active low
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // bus strobe
	input wire logic wb_ack_o, // bus acknowledge
	input wire logic wb_err_o, // bus error
	input wire logic combSyncPinOut, // comb sync drive
	input wire logic combSyncPinOe_b, // comb sync enable
	input wire logic firSyncPinOut, // FIR sync drive
	input wire logic firSyncPinOe_b, // FIR sync enable
	input wire logic outValid, // word strobe
	input wire logic softReset // soft reset level
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	sequence s_answer;
		(wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
	endsequence
	a_bus_answer: assert property (s_req |=> s_answer)
		else $error("bus request not answered in one cycle");
	a_no_spurious: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
		else $error("answer without request");
	a_pins_agree: assert property (combSyncPinOe_b == firSyncPinOe_b)
		else $error("sync pin enables differ");
	a_fir_on_comb: assert property (firSyncPinOut && !firSyncPinOe_b |-> combSyncPinOut)
		else $error("FIR pulse without comb pulse");
	a_role_change: assert property ($changed(combSyncPinOe_b) |-> wb_ack_o || $past(wb_ack_o))
		else $error("sync role changed without a write");
	a_reset_role: assert property (disable iff (1'b0) !rst_b |=> combSyncPinOe_b && softReset)
		else $error("reset did not give slave and soft reset");
	a_soft_hold: assert property (softReset |-> !outValid && !combSyncPinOut && !firSyncPinOut)
		else $error("activity during soft reset");
	a_slave_role: assert property (combSyncPinOe_b && firSyncPinOe_b |=> $stable(combSyncPinOe_b) || wb_ack_o)
		else $error("slave released pins on its own");
endmodule

bind rfs_top rfs_top_properties u_rfs_top_properties (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .combSyncPinOut(combSyncPinOut),
	.combSyncPinOe_b(combSyncPinOe_b), .firSyncPinOut(firSyncPinOut), .firSyncPinOe_b(firSyncPinOe_b),
	.outValid(outValid), .softReset(softReset));

/* File: test/rfs_sync_peer.sv */
// Purpose: Another driver on the shared sync pads, acting as master.
// Assumes: Pads are pulled low while nobody drives them.
// Notes: Pulses are one cycle, launched on request from the bench.
`timescale 1ns/10ps
module rfs_sync_peer (
	input wire logic clk, // clock
	input wire logic combGo, // request a comb pulse
	input wire logic firGo, // request a FIR pulse
	output logic drive, // peer drives the pads
	output logic combPulse, // comb pad drive
	output logic firPulse // FIR pad drive
);
	always_ff @(posedge clk) begin
		combPulse <= combGo;
		firPulse <= firGo;
		drive <= combGo || firGo;
	end
endmodule

/* File: test/rfs_top_tb.sv */
// Purpose: Self-checking bench for the FIR back end.
// Assumes: Sync pads are pulled low when nobody drives them.
// Notes: Raw results are read as wide words; narrow words are predicted from them.
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error %s expected %h seen %h", n, e, g); end end
module rfs_top_tb import rfs_pkg::*; ;
	localparam logic [17:0] SMP = 18'h10800;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, sampV = 1'b0, combGo = 1'b0, firGo = 1'b0, rdE;
	logic [13:0] wbAdr = 14'h0000;
	logic [31:0] wbDat = 32'h0, rdQ, r1, word, wbDatO;
	logic [31:0] words [2];
	logic [17:0] sampA = 18'h00000, sampB = 18'h00000;
	logic ack, err, cOut, cOe, fOut, fOe, s2, s5, oValid, softRst, peerDrv, peerComb, peerFir;
	logic combPad, firPad;
	int n_mismatch = 0, compares = 0, cyc = 0, cC, cF, c2, c5;
	int d [3];
	always #25 clk = ~clk;
	assign combPad = !cOe ? cOut : (peerDrv ? peerComb : 1'b0);
	assign firPad = !fOe ? fOut : (peerDrv ? peerFir : 1'b0);
	rfs_top u_rfs_top (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(ack), .wb_err_o(err),
		.sampleValid(sampV), .sampleA(sampA), .sampleB(sampB), .combSyncPinIn(combPad), .combSyncPinOut(cOut),
		.combSyncPinOe_b(cOe), .firSyncPinIn(firPad), .firSyncPinOut(fOut), .firSyncPinOe_b(fOe),
		.combTwoStrobe(s2), .combFiveStrobe(s5), .outValid(oValid), .outputPortWord(word), .softReset(softRst));
	rfs_sync_peer u_rfs_sync_peer (.clk(clk), .combGo(combGo), .firGo(firGo), .drive(peerDrv),
		.combPulse(peerComb), .firPulse(peerFir));
	task automatic wbx(input logic we, input logic [11:0] idx, input logic [31:0] dat);
		@(posedge clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= {idx, 2'b00};
		wbDat <= dat;
		@(posedge clk);
		while (ack !== 1'b1 && err !== 1'b1) @(posedge clk);
		rdQ = wbDatO;
		rdE = err;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask
	task automatic pass(input logic [17:0] b, input int n);
		int k;
		k = 0;
		@(posedge clk);
		sampA <= SMP;
		sampB <= b;
		sampV <= 1'b1;
		@(posedge clk);
		sampV <= 1'b0;
		while (k < n) begin
			@(posedge clk);
			if (oValid === 1'b1) begin
				words[k] = word;
				k++;
			end
		end
		repeat (4) @(posedge clk);
	endtask
	task automatic cnt(input int n);
		{cC, cF, c2, c5} = 0;
		repeat (n) begin
			@(posedge clk);
			cC += int'(combPad === 1'b1);
			cF += int'(firPad === 1'b1);
			c2 += int'(s2 === 1'b1);
			c5 += int'(s5 === 1'b1);
		end
	endtask
	// Half-up rounding of the result scaled by two to (-3 - s), kept to 16 signed bits.
	function automatic logic [31:0] scl(input logic signed [31:0] r, input int s);
		logic signed [31:0] v;
		v = ((r <<< 4) + (32'sd1 <<< (s + 6))) >>> (s + 7);
		if (v > 32767) v = 32767;
		if (v < -32768) v = -32768;
		return {16'h0000, v[15:0]};
	endfunction
	task automatic t_regs;
		`CHK("softReset", 1'b1, softRst)
		wbx(1'b0, RFS_IDX_MODE, 32'h0);
		`CHK("mode", 32'h00000001, rdQ)
		wbx(1'b0, RFS_IDX_OUTCTL, 32'h0);
		`CHK("outctl", 32'h00000004, rdQ)
		wbx(1'b0, 12'h200, 32'h0);
		`CHK("unmapped", 1'b1, rdE)
		`CHK("slave enables", 2'b11, {cOe, fOe})
		wbx(1'b1, RFS_IDX_MODE, 32'h0);
		wbx(1'b1, RFS_IDX_NTAPS, 32'h0);
		wbx(1'b1, RFS_IDX_OWIDTH, 32'h1);
		// one tap, A even and B odd
		wbx(1'b1, 12'h005, 32'h01000);
		wbx(1'b1, 12'h006, 32'h02000);
		wbx(1'b1, 12'h007, 32'hff000);
		$display("regs done");
	endtask
	task automatic t_win;
		wbx(1'b1, RFS_IDX_CBASE, 32'h5);
		pass(18'h0, 1);
		r1 = words[0];
		`CHK("result nonzero", 1'b1, r1 != 32'h0)
		wbx(1'b1, RFS_IDX_CBASE, 32'h6);
		pass(18'h0, 1);
		`CHK("base six", r1 << 1, words[0])
		wbx(1'b1, RFS_IDX_CBASE, 32'h7);
		pass(18'h0, 1);
		`CHK("negative coef", -r1, words[0])
		wbx(1'b1, RFS_IDX_OUTCTL, 32'h0);
		wbx(1'b1, RFS_IDX_CBASE, 32'h5);
		pass(18'h0, 1);
		`CHK("wide ignores scale", r1, words[0])
		$display("window done");
	endtask
	task automatic t_scale;
		wbx(1'b1, RFS_IDX_OWIDTH, 32'h0);
		for (int s = 0; s < 8; s++) begin
			wbx(1'b1, RFS_IDX_OUTCTL, 32'(s));
			pass(18'h0, 1);
			`CHK("scaled word", scl(r1, s), words[0])
		end
		wbx(1'b1, RFS_IDX_OUTCTL, 32'h4);
		$display("scale done");
	endtask
	task automatic t_ub;
		wbx(1'b1, RFS_IDX_OWIDTH, 32'h1);
		wbx(1'b1, RFS_IDX_CBASE, 32'h6);
		wbx(1'b1, RFS_IDX_MODE, 32'h2);
		pass(SMP, 2);
		`CHK("shared A", r1 << 1, words[0])
		`CHK("shared B", r1 << 1, words[1])
		wbx(1'b1, RFS_IDX_OUTCTL, 32'hc);
		wbx(1'b0, RFS_IDX_STATUS, 32'h0);
		`CHK("unique on", 1'b1, rdQ[5])
		pass(SMP, 2);
		`CHK("unique A", r1 << 1, words[0])
		`CHK("unique B", -r1, words[1])
		wbx(1'b1, RFS_IDX_MODE, 32'h0);
		wbx(1'b0, RFS_IDX_STATUS, 32'h0);
		`CHK("unique off", 1'b0, rdQ[5])
		pass(18'h0, 1);
		`CHK("single channel", r1 << 1, words[0])
		$display("unique B done");
	endtask
	task automatic t_sync;
		wbx(1'b1, RFS_IDX_DECIM, 32'h020002);
		cnt(90);
		`CHK("free comb two", 30, c2)
		`CHK("free comb five", 30, c5)
		`CHK("slave quiet", 0, cC)
		for (int j = 0; j < 3; j++) begin
			repeat (j + 4) @(posedge clk);
			combGo <= 1'b1;
			@(posedge clk);
			combGo <= 1'b0;
			// The pad pulse stands in the next cycle; from two edges on the strobe shows the new phase.
			repeat (2) @(posedge clk);
			d[j] = 0;
			while (s2 !== 1'b1 && d[j] < 20) begin
				@(posedge clk);
				d[j]++;
			end
			`CHK("realign", 2, d[j])
		end
		wbx(1'b1, RFS_IDX_MODE, 32'h8);
		`CHK("master enables", 2'b00, {cOe, fOe})
		cnt(90);
		`CHK("comb pulses", 30, cC)
		`CHK("fir pulses", 10, cF)
		`CHK("own readback", 30, c2)
		$display("sync done");
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			test_done();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_win();
		t_scale();
		t_ub();
		t_sync();
		test_done();
	end
endmodule
